// ==== src/self_test_pkg.sv ====
package self_test_pkg;

  // ****************************************
  // test numbering
  // ****************************************
  localparam int          NUM_TESTS    = 24;
  localparam int          NUM_CHANNELS = 9;
  localparam logic [4:0]  T_CHAN0      = 5'h00;
  localparam logic [4:0]  T_MASTER     = 5'h09;
  localparam logic [4:0]  T_SUPPLY0    = 5'h0A;
  localparam logic [4:0]  T_TEMP       = 5'h11;
  localparam logic [4:0]  T_RAM        = 5'h12;
  localparam logic [4:0]  T_ROM        = 5'h13;
  localparam logic [4:0]  T_ADC        = 5'h14;
  localparam logic [4:0]  T_SETTINGS   = 5'h15;
  localparam logic [4:0]  T_EEPROM     = 5'h16;
  localparam logic [4:0]  T_BOARD      = 5'h17;
  localparam logic [1:0]  SUM_ROM      = 2'h0;
  localparam logic [1:0]  SUM_SETTINGS = 2'h1;
  localparam logic [1:0]  SUM_EEPROM   = 2'h2;

  // ****************************************
  // limits, millivolts and degrees celsius
  // ****************************************
  localparam logic signed [16:0] CHAN_WARN_MV   = 17'sd30;
  localparam logic signed [16:0] MASTER_WARN_MV = 17'sd20;
  localparam logic signed [16:0] MASTER_FAIL_MV = 17'sd30;
  localparam logic signed [15:0] TEMP_WARN_LO   = -16'sd40;
  localparam logic signed [15:0] TEMP_WARN_HI   = 16'sd85;
  localparam logic signed [15:0] TEMP_FAIL_LO   = -16'sd50;
  localparam logic signed [15:0] TEMP_FAIL_HI   = 16'sd100;
  // +5 ps, +5 reg, -5 reg, +12, -12, +15, -15
  localparam logic signed [15:0] SUP_WARN_LO [7] =
    '{16'sd4800, 16'sd4750, -16'sd5250, 16'sd11500, -16'sd12500, 16'sd14400, -16'sd15600};
  localparam logic signed [15:0] SUP_WARN_HI [7] =
    '{16'sd5200, 16'sd5200, -16'sd4750, 16'sd12500, -16'sd11500, 16'sd15600, -16'sd14400};
  localparam logic signed [15:0] SUP_FAIL_LO [7] =
    '{16'sd4650, 16'sd4500, -16'sd5400, 16'sd11200, -16'sd14000, 16'sd14000, -16'sd16000};
  localparam logic signed [15:0] SUP_FAIL_HI [7] =
    '{16'sd5400, 16'sd5400, -16'sd4500, 16'sd14000, -16'sd11200, 16'sd16000, -16'sd14000};

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS      = 5;
  localparam int CLK_HZ             = 200_000_000;
  localparam int ALARM_PULSE_S      = 5;
  localparam int ALARM_PULSE_DEFAULT = ALARM_PULSE_S * CLK_HZ;
  localparam int CONV_LIMIT_NS      = 10_000;
  localparam logic [11:0] CONV_LIMIT_CYCLES = 12'(CONV_LIMIT_NS / CLK_PERIOD_NS);
  localparam logic [1:0]  REF_SETTLE  = 2'h3;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_WARN      = 8'h04;
  localparam logic [7:0]  A_FAIL      = 8'h08;
  localparam logic [7:0]  A_STATE     = 8'h0C;
  localparam logic [7:0]  A_BOARD_REF = 8'h10;
  localparam logic [7:0]  A_MARK      = 8'h14;
  localparam int          CTRL_RUN    = 0;
  localparam int          CTRL_RELOAD = 1;
  localparam logic        CTRL_RUN_RESET = 1'b1;
  localparam logic [7:0]  MARK_WARN   = 8'h57;
  localparam logic [7:0]  MARK_FAIL   = 8'h46;
  localparam logic [7:0]  MARK_OK     = 8'h2E;

  typedef enum logic [0:0] {ST_SELECT, ST_WAIT} seq_type;

endpackage

// ==== src/limit_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module limit_checker (
  // test and sample
  input  wire logic [4:0]         idx,
  input  wire logic signed [15:0] value,
  // verdict
  output logic                    warn,
  output logic                    fail
);
  import self_test_pkg::*;

  logic signed [16:0] mag;
  logic [2:0]         sup;

  assign mag = value[15] ? -17'(value) : 17'(value);
  assign sup = 3'(idx - T_SUPPLY0);

  always_comb begin
    warn = 1'b0;
    fail = 1'b0;
    if (idx < T_MASTER) begin
      warn = mag > CHAN_WARN_MV;  // (R1)
    end else if (idx == T_MASTER) begin
      warn = mag > MASTER_WARN_MV;  // (R3)
      fail = mag > MASTER_FAIL_MV;  // (R4)
    end else if (idx < T_TEMP) begin
      warn = value < SUP_WARN_LO[sup] || value > SUP_WARN_HI[sup];  // (R5)
      fail = value < SUP_FAIL_LO[sup] || value > SUP_FAIL_HI[sup];  // (R5)
    end else if (idx == T_TEMP) begin
      warn = value < TEMP_WARN_LO || value > TEMP_WARN_HI;  // (R6)
      fail = value < TEMP_FAIL_LO || value > TEMP_FAIL_HI;  // (R7)
    end
  end

endmodule
`default_nettype wire

// ==== src/self_test_status_monitor.sv ====
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R1) channel offset beyond 30 mV warns
// (R2) grounded input sampled as master offset
// (R3) master offset above 20 mV warns
// (R4) master offset above 30 mV fails
// (R5) supply rails checked against warn, fail bands
// (R6) temperature outside -40..85 C warns
// (R7) temperature outside -50..100 C fails
// (R8) temperature warning never pulses alarm
// (R9) warning: serial request, five second pulse
// (R10) failure: serial, panel request, latched alarm
// (R11) status marks W for warn, F fail
// (R12) bad ram write or read fails
// (R13) flash checksum mismatch fails
// (R14) slow or unfinished conversion fails
// (R15) settings memory checksum mismatch fails
// (R16) eeprom checksum mismatch fails
// (R17) board identity mismatch against reference fails
// (R18) host reload command refreshes board reference
// (R19) any failure disables protection, freezes outputs
// (R20) round robin retest, failures latch until reset
module self_test_status_monitor #(
  parameter int unsigned ALARM_PULSE_CYCLES = self_test_pkg::ALARM_PULSE_DEFAULT
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // converter mux
  output logic [4:0]       mux_sel,
  output logic             conv_start,
  input  wire logic        sample_valid,
  input  wire logic signed [15:0] sample_value,
  // memory checks
  input  wire logic        ram_test_valid,
  input  wire logic        ram_test_ok,
  input  wire logic        sum_valid,
  input  wire logic [1:0]  sum_sel,
  input  wire logic [15:0] sum_computed,
  input  wire logic [15:0] sum_stored,
  // board identity pins
  input  wire logic [7:0]  board_id_pins,
  // notification and protection
  output logic             alarm_contact,
  output logic             serial_msg_req,
  output logic             panel_fail_req,
  output logic             protection_enable,
  output logic             outputs_freeze
);
  import self_test_pkg::*;

  // ****************************************
  // state
  // ****************************************
  seq_type               state;
  logic [4:0]            idx;
  logic [11:0]           wait_cnt;
  logic [NUM_TESTS-1:0]  warn;
  logic [NUM_TESTS-1:0]  fail;
  logic [NUM_TESTS-1:0]  next_warn;
  logic [NUM_TESTS-1:0]  fail_set;
  logic                  run;
  logic [7:0]            board_ref;
  logic                  ref_valid;
  logic [1:0]            settle_cnt;
  logic [4:0]            mark_sel;
  logic [7:0]            id_meta;
  logic [7:0]            id_sync;
  logic [29:0]           pulse_cnt;

  // ****************************************
  // round robin sequencer
  // ****************************************
  logic chk_warn;
  logic chk_fail;
  logic taken;
  logic timeout;
  logic [4:0] next_idx;

  limit_checker u_limit (
    .idx   (idx),
    .value (sample_value),
    .warn  (chk_warn),
    .fail  (chk_fail)
  );

  assign taken      = (state == ST_WAIT) && sample_valid;
  assign timeout    = (state == ST_WAIT) && !sample_valid && wait_cnt == CONV_LIMIT_CYCLES;
  assign next_idx   = (idx == T_TEMP) ? T_CHAN0 : idx + 5'h01;
  assign conv_start = (state == ST_SELECT) && run;
  assign mux_sel    = idx;  // (R2)

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_SELECT;
      idx      <= T_CHAN0;
      wait_cnt <= 12'h000;
    end else begin
      unique case (state)
        ST_SELECT: begin
          wait_cnt <= 12'h000;
          if (run) state <= ST_WAIT;
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt + 12'h001;
          if (taken || timeout) begin
            state <= ST_SELECT;
            idx   <= next_idx;  // (R20)
          end
        end
      endcase
    end
  end

  // ****************************************
  // warning and failure flags
  // ****************************************
  logic        id_bad;
  logic        sum_bad;
  logic [NUM_TESTS-1:0] warn_rise;
  logic        pulse_trig;
  logic        new_event;
  logic        fail_any;

  assign id_bad  = ref_valid && (id_sync != board_ref);
  assign sum_bad = sum_valid && (sum_computed != sum_stored);

  always_comb begin
    next_warn = warn;
    fail_set  = '0;
    if (taken) begin
      next_warn[idx] = chk_warn;  // (R20)
      fail_set[idx]  = chk_fail;  // (R4)
    end
    fail_set[T_ADC]      = timeout;  // (R14)
    fail_set[T_RAM]      = ram_test_valid && !ram_test_ok;  // (R12)
    fail_set[T_ROM]      = sum_bad && sum_sel == SUM_ROM;  // (R13)
    fail_set[T_SETTINGS] = sum_bad && sum_sel == SUM_SETTINGS;  // (R15)
    fail_set[T_EEPROM]   = sum_bad && sum_sel == SUM_EEPROM;  // (R16)
    fail_set[T_BOARD]    = id_bad;  // (R17)
  end

  assign warn_rise  = next_warn & ~warn;
  assign pulse_trig = |(warn_rise & ~(NUM_TESTS'(1) << T_TEMP));  // (R8)
  assign new_event  = (|warn_rise) || (|(fail_set & ~fail));
  assign fail_any   = |fail;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      warn           <= '0;
      fail           <= '0;
      serial_msg_req <= 1'b0;
    end else begin
      warn           <= next_warn;
      fail           <= fail | fail_set;  // (R20)
      serial_msg_req <= new_event;  // (R9) (R10)
    end
  end

  // ****************************************
  // alarm contact and protection
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_cnt         <= 30'h0000_0000;
      alarm_contact     <= 1'b0;
      panel_fail_req    <= 1'b0;
      protection_enable <= 1'b0;
      outputs_freeze    <= 1'b0;
    end else begin
      if (pulse_trig) pulse_cnt <= 30'(ALARM_PULSE_CYCLES);  // (R9)
      else if (pulse_cnt != 30'h0000_0000) pulse_cnt <= pulse_cnt - 30'h0000_0001;
      alarm_contact     <= fail_any || pulse_trig || pulse_cnt > 30'h0000_0001;  // (R10)
      panel_fail_req    <= fail_any;  // (R10)
      protection_enable <= !fail_any;  // (R19)
      outputs_freeze    <= fail_any;  // (R19)
    end
  end

  // ****************************************
  // board identity reference
  // ****************************************
  logic reload;
  logic wr_hit;

  assign wr_hit = psel && penable && pwrite;
  assign reload = wr_hit && paddr == A_CTRL && pwdata[CTRL_RELOAD];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      id_meta <= 8'h00;
      id_sync <= 8'h00;
    end else begin
      id_meta <= board_id_pins;
      id_sync <= id_meta;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      board_ref  <= 8'h00;
      ref_valid  <= 1'b0;
      settle_cnt <= 2'h0;
    end else begin
      if (settle_cnt != REF_SETTLE) settle_cnt <= settle_cnt + 2'h1;
      if (reload || (!ref_valid && settle_cnt == REF_SETTLE)) begin
        board_ref <= id_sync;  // (R18)
        ref_valid <= 1'b1;
      end
    end
  end

  // ****************************************
  // apb register file
  // ****************************************
  logic        addr_hit;
  logic [7:0]  mark;
  logic [31:0] rd_mux;

  assign addr_hit = paddr == A_CTRL || paddr == A_WARN || paddr == A_FAIL
                 || paddr == A_STATE || paddr == A_BOARD_REF || paddr == A_MARK;
  assign mark     = fail[mark_sel] ? MARK_FAIL : warn[mark_sel] ? MARK_WARN : MARK_OK;  // (R11)
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      A_CTRL:      rd_mux = {31'h0000_0000, run};
      A_WARN:      rd_mux = {8'h00, warn};
      A_FAIL:      rd_mux = {8'h00, fail};
      A_STATE:     rd_mux = {28'h000_0000, outputs_freeze, protection_enable,
                             panel_fail_req, alarm_contact};
      A_BOARD_REF: rd_mux = {23'h00_0000, ref_valid, board_ref};
      A_MARK:      rd_mux = {19'h0_0000, mark_sel, mark};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata   <= 32'h0000_0000;
      run      <= CTRL_RUN_RESET;
      mark_sel <= 5'h00;
    end else begin
      if (psel && !penable && !pwrite) prdata <= rd_mux;
      if (wr_hit && paddr == A_CTRL) run <= pwdata[CTRL_RUN];
      if (wr_hit && paddr == A_MARK) mark_sel <= pwdata[12:8];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_fail_sticky: assert property (@(posedge ref_clk) disable iff (rst)  // (R20)
    !(|($past(fail) & ~fail))) else $error("failure flag dropped");
  a_fail_alarm: assert property (@(posedge ref_clk) disable iff (rst)  // (R10)
    fail_any |=> alarm_contact && panel_fail_req) else $error("failure not latched on alarm");
  a_protect_off: assert property (@(posedge ref_clk) disable iff (rst)  // (R19)
    fail_any |=> !protection_enable && outputs_freeze) else $error("protection not frozen");
  a_warn_pulse: assert property (@(posedge ref_clk) disable iff (rst)  // (R9)
    pulse_trig |=> alarm_contact && serial_msg_req) else $error("warning pulse missing");
  a_temp_quiet: assert property (@(posedge ref_clk) disable iff (rst)  // (R8)
    (warn_rise == (NUM_TESTS'(1) << T_TEMP)) && pulse_cnt == 30'h0000_0000 && !fail_any
    |=> !alarm_contact) else $error("temperature warning pulsed alarm");
  a_conv_timeout: assert property (@(posedge ref_clk) disable iff (rst)  // (R14)
    state == ST_WAIT && !sample_valid && wait_cnt == CONV_LIMIT_CYCLES
    |=> fail[T_ADC]) else $error("slow conversion not failed");
  a_master_fail: assert property (@(posedge ref_clk) disable iff (rst)  // (R4)
    taken && idx == T_MASTER && sample_value > 16'sd30 |=> fail[T_MASTER] && warn[T_MASTER])
    else $error("master offset failure missed");
  a_ram_fail: assert property (@(posedge ref_clk) disable iff (rst)  // (R12)
    ram_test_valid && !ram_test_ok |=> fail[T_RAM] && !warn[T_RAM])
    else $error("ram failure missed");
  a_board_fail: assert property (@(posedge ref_clk) disable iff (rst)  // (R17)
    ref_valid && id_sync != board_ref && !reload |=> fail[T_BOARD])
    else $error("board mismatch missed");

endmodule
`default_nettype wire

// ==== testbench/converter_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********************************************
// converter answering each start after a delay, unless hang is set
// ********************************************
module converter_model (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // converter side
  input  wire logic [4:0]         mux_sel,
  input  wire logic               conv_start,
  output logic                    sample_valid,
  output logic signed [15:0]      sample_value,
  // bench control
  input  wire logic signed [15:0] level [18],
  input  wire logic [3:0]         dly,
  input  wire logic               hang
);
  logic [3:0] cnt;
  logic [4:0] sel;

  // idle data toggles so a stale value is never mistaken for a result
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      sel <= 5'h00;
      sample_valid <= 1'b0;
      sample_value <= 16'sh0000;
    end else begin
      sample_valid <= 1'b0;
      sample_value <= ~sample_value;
      if (conv_start && !hang) begin
        cnt <= dly;
        sel <= mux_sel;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          sample_valid <= 1'b1;
          sample_value <= level[sel];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_self_test_status_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_self_test_status_monitor;
  import self_test_pkg::*;
  // ****************
  // signals
  // ****************
  localparam int PULSE = 50;
  localparam int LIMIT = 60000;
  localparam int NOM [7] = '{5000, 5000, -5000, 12000, -12000, 15000, -15000};
  localparam logic [4:0] FBIT [9] = '{T_MASTER, T_TEMP, 5'h0D, T_RAM, T_ROM, T_SETTINGS,
                                      T_EEPROM, T_ADC, T_BOARD};
  logic               ref_clk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]         paddr, board_id_pins;
  logic [31:0]        pwdata, prdata, rd, ew, ef;
  logic [4:0]         mux_sel;
  logic               conv_start, sample_valid, ram_test_valid, ram_test_ok, sum_valid, hang;
  logic signed [15:0] sample_value;
  logic signed [15:0] level [18];
  logic [1:0]         sum_sel;
  logic [15:0]        sum_computed, sum_stored;
  logic               alarm_contact, serial_msg_req, panel_fail_req;
  logic               protection_enable, outputs_freeze;
  logic [3:0]         dly;
  int                 err_count, cmp_count, cyc, run, last_run, rises, msgs, r0;

  self_test_status_monitor #(.ALARM_PULSE_CYCLES(PULSE)) i_self_test_status_monitor (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mux_sel(mux_sel), .conv_start(conv_start), .sample_valid(sample_valid),
    .sample_value(sample_value), .ram_test_valid(ram_test_valid), .ram_test_ok(ram_test_ok),
    .sum_valid(sum_valid), .sum_sel(sum_sel), .sum_computed(sum_computed),
    .sum_stored(sum_stored), .board_id_pins(board_id_pins), .alarm_contact(alarm_contact),
    .serial_msg_req(serial_msg_req), .panel_fail_req(panel_fail_req),
    .protection_enable(protection_enable), .outputs_freeze(outputs_freeze));
  converter_model i_converter_model (.ref_clk(ref_clk), .rst(rst), .mux_sel(mux_sel),
    .conv_start(conv_start), .sample_valid(sample_valid), .sample_value(sample_value),
    .level(level), .dly(dly), .hang(hang));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // alarm pulse length, alarm rises, serial requests, timeout
  always @(negedge ref_clk) begin
    cyc++;
    if (alarm_contact === 1'b1) begin
      if (run == 0) rises++;
      run++;
    end else begin
      if (run > 0) last_run = run;
      run = 0;
    end
    if (serial_msg_req === 1'b1) msgs++;
    if (cyc >= LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic int nominal(input int i);
    if (i < 10) return 0;
    if (i == 17) return 25;
    return NOM[i - 10];
  endfunction

  // {warn, fail} for one measured test
  function automatic logic [1:0] exp_wf(input int i, input int v);
    int a, s;
    a = (v < 0) ? -v : v;
    s = i - 10;
    if (i < 9) return {a > 30, 1'b0};
    if (i == 9) return {a > 20, a > 30};
    if (i == 17) return {v < -40 || v > 85, v < -50 || v > 100};
    return {v < SUP_WARN_LO[s] || v > SUP_WARN_HI[s], v < SUP_FAIL_LO[s] || v > SUP_FAIL_HI[s]};
  endfunction

  task automatic do_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    hang <= 1'b0;
    board_id_pins <= 8'h5A;
    for (int i = 0; i < 18; i++) level[i] <= 16'(nominal(i));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // counts starts of test 0, so two starts mean one full sweep
  task automatic rounds(input int n);
    int k, t;
    k = 0;
    t = 0;
    while (k < n && t < 5000) begin
      @(negedge ref_clk);
      t++;
      if (conv_start === 1'b1 && mux_sel === T_CHAN0) k++;
    end
    chk("sweep count", 32'(n), 32'(k));
  endtask

  task automatic mem_pulse(input int k, input logic good);
    logic [15:0] s;
    s = 16'($urandom);
    @(posedge ref_clk);
    ram_test_valid <= (k == 0);
    ram_test_ok <= good;
    sum_valid <= (k != 0);
    sum_sel <= 2'(k - 1);
    sum_stored <= s;
    sum_computed <= good ? s : s ^ 16'h0001;
    @(posedge ref_clk);
    ram_test_valid <= 1'b0;
    sum_valid <= 1'b0;
  endtask

  task automatic mark(input logic [4:0] idx, input logic [7:0] m);
    apb(1'b1, A_MARK, {19'h0, idx, 8'h00});
    apb(1'b0, A_MARK, 32'h0000_0000);
    chk("status mark", {19'h0, idx, m}, rd);
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, ram_test_valid, sum_valid, hang} = '0;
    {paddr, pwdata, sum_sel, sum_computed, sum_stored} = '0;
    ram_test_ok = 1'b1;
    board_id_pins = 8'h5A;
    dly = 4'h2;
    for (int i = 0; i < 18; i++) level[i] = 16'(nominal(i));
    void'($urandom(77));
    do_reset();
    apb(1'b0, A_CTRL, 32'h0000_0000);
    chk("run after reset", 32'(CTRL_RUN_RESET), 32'(rd[0]));
    apb(1'b0, A_STATE, 32'h0000_0000);
    chk("state after reset", 32'h0000_0004, rd);
    apb(1'b0, A_BOARD_REF, 32'h0000_0000);
    chk("board reference", 32'h0000_015A, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(perr));
    apb(1'b1, A_CTRL, 32'h0000_0000);
    r0 = 0;
    repeat (40) @(negedge ref_clk) r0 += int'(conv_start === 1'b1);
    chk("start while stopped", 32'h0000_0000, 32'(r0));
    apb(1'b1, A_CTRL, 32'h0000_0001);
    $display("test reset done");
    level[3] <= 16'sd31;
    level[2] <= 16'sd30;
    level[9] <= 16'sd20;
    msgs = 0;
    rounds(2);
    apb(1'b0, A_WARN, 32'h0000_0000);
    chk("warn flags", 32'h0000_0008, rd);
    for (int t = 0; t < 200 && alarm_contact !== 1'b0; t++) @(negedge ref_clk);
    chk("alarm pulse", 32'(PULSE), 32'(last_run));
    chk("serial request", 32'h0000_0001, 32'(msgs != 0));
    mark(5'h03, MARK_WARN);
    mark(5'h02, MARK_OK);
    level[3] <= 16'sd0;
    level[17] <= 16'sd86;
    r0 = rises;
    rounds(2);
    apb(1'b0, A_WARN, 32'h0000_0000);
    chk("warn flags", 32'h0002_0000, rd);
    chk("alarm rises", 32'(r0), 32'(rises));
    $display("test warnings done");
    repeat (4) begin
      do_reset();
      dly <= 4'($urandom_range(1, 8));
      for (int i = 0; i < 18; i++) begin
        int v, sp;
        logic [1:0] wf;
        sp = (i < 9) ? 40 : (i == 9) ? 35 : (i == 17) ? 85 :
             ((nominal(i) < 0) ? -nominal(i) : nominal(i)) / 12;
        v = nominal(i) + int'($urandom_range(0, 2 * sp)) - sp;
        level[i] <= 16'(v);
        wf = exp_wf(i, v);
        ew[i] = wf[1];
        ef[i] = wf[0];
      end
      ew[31:18] = '0;
      ef[31:18] = '0;
      for (int k = 0; k < 4; k++) mem_pulse(k, 1'b1);
      rounds(2);
      apb(1'b0, A_WARN, 32'h0000_0000);
      chk("warn flags", ew, rd);
      apb(1'b0, A_FAIL, 32'h0000_0000);
      chk("fail flags", ef, rd);
    end
    $display("test random limits done");
    for (int c = 0; c < 9; c++) begin
      do_reset();
      msgs = 0;
      case (c)
        0: level[9] <= 16'sd31;
        1: level[17] <= 16'sd101;
        2: level[13] <= 16'sd14100;
        7: hang <= 1'b1;
        8: board_id_pins <= 8'hA5;
        default: mem_pulse(c - 3, 1'b0);
      endcase
      rd = '0;
      for (int t = 0; t < 1000 && rd == 32'h0; t++) apb(1'b0, A_FAIL, 32'h0000_0000);
      chk("fail flags", 32'h1 << FBIT[c], rd);
      repeat (2 * PULSE) @(posedge ref_clk);
      apb(1'b0, A_STATE, 32'h0000_0000);
      chk("state", 32'h0000_000B, rd);
      chk("serial request", 32'h0000_0001, 32'(msgs != 0));
      mark(FBIT[c], MARK_FAIL);
      if (c == 8) begin
        apb(1'b1, A_CTRL, 32'h0000_0003);
        apb(1'b0, A_BOARD_REF, 32'h0000_0000);
        chk("board reference", 32'h0000_01A5, rd);
      end
    end
    $display("test failures done");
    print_verdict();
  end
endmodule
`default_nettype wire
